// File: rtl/afe_pkg.sv
// Purpose: Shared constants and types for the battery front-end link.
// Assumes: 250 MHz reference clock on both ends.
// Notes:   Command is 6 bits: bits 5..3 address, bits 2..0 data.
`default_nettype none
package afe_pkg;

    // ------------------------------------------------------------
    // Command format
    // ------------------------------------------------------------
    localparam int          CMD_W      = 6;
    localparam logic [2:0]  CMD_BITS   = 3'h6;
    localparam logic [2:0]  ADDR_RESET = 3'h0;
    localparam logic [2:0]  ADDR_MON   = 3'h1;
    localparam logic [2:0]  ADDR_FET   = 3'h2;
    localparam logic [2:0]  ADDR_MUX   = 3'h3;
    localparam logic [2:0]  ADDR_REG   = 3'h4;
    localparam logic [2:0]  ADDR_BAL   = 3'h5;
    localparam logic [2:0]  MUX_RUN    = 3'h1;
    localparam logic [2:0]  REG_33A    = 3'h0;
    localparam logic [2:0]  REG_OFF    = 3'h1;
    localparam logic [2:0]  REG_50     = 3'h2;
    localparam logic [2:0]  REG_33B    = 3'h3;
    localparam logic [2:0]  BAL_OFF    = 3'h0;
    localparam logic [2:0]  BAL_CELL4  = 3'h4;
    localparam logic [5:0]  CMD_RESUME = 6'h00;

    // ------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------
    localparam int          TAP_W      = 10;
    localparam int          CELLS      = 4;
    localparam logic [2:0]  MON_SEL_RST = 3'h0;
    localparam logic [3:0]  BAL_RST     = 4'h0;
    localparam logic [2:0]  FET_RST     = 3'h7;

    // ------------------------------------------------------------
    // Host register map (Avalon-MM byte addresses)
    // ------------------------------------------------------------
    localparam int          HOST_AW          = 4;
    localparam logic [3:0]  HOST_ADDR_CMD    = 4'h0;
    localparam logic [3:0]  HOST_ADDR_STATUS = 4'h4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 4;
    localparam int SERIAL_SETUP_NS = 600;
    localparam int SERIAL_HALF_CYC = SERIAL_SETUP_NS / CLK_PERIOD_NS;
    localparam int MON_SETTLE_CYC  = 100_000 / CLK_PERIOD_NS;
    localparam int REG_SETTLE_CYC  = 10_000_000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_USUAL, MODE_SAVE, MODE_DOWN}
        power_mode_t;
    typedef enum logic {LEVEL_3V3, LEVEL_5V0} reg_level_t;
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_FINISH, H_SETTLE}
        host_state_t;

endpackage
`default_nettype wire

// File: rtl/afe_link_if.sv
// Purpose: Three-wire command link plus reset line between the ends.
// Assumes: Host drives the shift clock; device drives the reset line.
// Notes:   Plain wires, no clocking block.
`default_nettype none
interface afe_link_if;
    logic serial_shift_clock;
    logic serial_data_in;
    logic chip_select_n;
    logic host_reset_n;

    modport device (
        input  serial_shift_clock,
        input  serial_data_in,
        input  chip_select_n,
        output host_reset_n
    );
    modport host (
        output serial_shift_clock,
        output serial_data_in,
        output chip_select_n,
        input  host_reset_n
    );
endinterface
`default_nettype wire

// File: rtl/afe_sync.sv
// Purpose: Two-flop synchroniser for a bundle of level inputs.
// Assumes: Each bit is an independent slow level.
// Notes:   First stage feeds only the second stage.
`default_nettype none
module afe_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// File: rtl/afe_device.sv
// Purpose: Mode, switch and regulator control of the front-end device.
// Assumes: Link pins and analog levels are asynchronous to ref_clk_in.
// Notes:   Link inputs are sampled by ref_clk_in.
`default_nettype none
// Notes on behaviour
// (RL1) Three power modes, changed only by commands
// (RL2) Ground select stops detection, enters power save
// (RL3) Cell or offset select returns usual mode
// (RL4) Regulator stays on in power save
// (RL5) Host sends power-down only on low battery
// (RL6) Power-down: discharge high, pulldown, regulator off
// (RL7) Powered down: all drives high, commands refused
// (RL8) Powered down: all tap switches open
// (RL9) Charger sense high restarts regulator
// (RL10) Host resumes; device leaves down on resume
// (RL11) Host reset low while regulator below level
// (RL12) Cell voltage: upper tap, next lower tap
// (RL13) Offset: both taps of lower node
// (RL14) Regulator 3.3 V default, 5 V selectable
// (RL15) Conditioning closes one cell switch
// (RL16) Conditioning commands accumulate closed switches
// (RL17) Host waits 100 us after monitor change
// (RL18) Host waits 10 ms after regulator change
// (RL19) LSB first on rising clock, latch on select
// (RL20) Reset drives all switch drives high
// (RL21) Regulator off code is power-down
// (RL22) Select high bit offset, low bits cell
// (RL23) Only complete commands change state
// (RL24) Reset: ground select, switches open, power save
module afe_device
    import afe_pkg::*;
(
    input  wire logic               ref_clk_in,
    input  wire logic               reset_in,
    afe_link_if.device              link,
    input  wire logic               charger_sense_input_in,
    input  wire logic               regulator_ok_in,
    output power_mode_t             power_mode_out,
    output reg_level_t              reg_level_out,
    output logic                    regulator_enable_out,
    output logic                    detect_enable_out,
    output logic                    monitor_ground_out,
    output logic [TAP_W-1:0]        tap_switch_out,
    output logic [CELLS-1:0]        balance_switch_out,
    output logic                    charge_switch_drive_out,
    output logic                    discharge_switch_drive_out,
    output logic                    precharge_switch_drive_out,
    output logic                    charger_pulldown_out
);

    // ------------------------------------------------------------
    // Input sampling
    // ------------------------------------------------------------
    logic [4:0] pins_sync;
    wire        sck_s    = pins_sync[0];
    wire        sdi_s    = pins_sync[1];
    wire        cs_n_s   = pins_sync[2];
    wire        charger_s = pins_sync[3];
    wire        reg_ok_s = pins_sync[4];

    afe_sync #(.WIDTH(5)) u_sync (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .async_in   ({regulator_ok_in, charger_sense_input_in,
                      link.chip_select_n, link.serial_data_in,
                      link.serial_shift_clock}),
        .sync_out   (pins_sync)
    );

    // ------------------------------------------------------------
    // Serial shifter
    // ------------------------------------------------------------
    logic             sck_prev_reg;
    logic             cs_prev_reg;
    logic [CMD_W-1:0] shift_reg;
    logic [2:0]       bit_cnt_reg;

    wire sck_rise   = sck_s & ~sck_prev_reg;
    wire cs_rise    = cs_n_s & ~cs_prev_reg;
    wire shift_en   = ~cs_n_s & sck_rise;
    // (RL23) Complete frames only
    wire cmd_strobe = cs_rise & (bit_cnt_reg == CMD_BITS);
    wire [2:0] cmd_addr = shift_reg[5:3];
    wire [2:0] cmd_data = shift_reg[2:0];

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            sck_prev_reg <= 1'b0;
            cs_prev_reg  <= 1'b1;
            shift_reg    <= '0;
            bit_cnt_reg  <= 3'h0;
        end else begin
            sck_prev_reg <= sck_s;
            cs_prev_reg  <= cs_n_s;
            // (RL19) LSB first shift
            if (shift_en) begin
                shift_reg <= {sdi_s, shift_reg[CMD_W-1:1]};
            end
            if (cs_n_s) begin
                bit_cnt_reg <= 3'h0;
            end else if (shift_en && bit_cnt_reg != CMD_BITS) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    power_mode_t mode_reg;
    power_mode_t mode_next;
    reg_level_t  level_reg;
    reg_level_t  level_next;
    logic [2:0]  mon_sel_reg;
    logic [2:0]  mon_sel_next;
    logic [2:0]  fet_reg;
    logic [2:0]  fet_next;
    logic [3:0]  bal_reg;
    logic [3:0]  bal_next;
    logic        reg_on_reg;
    logic        reg_on_next;

    // Upper codes alias cells 1 to 3
    wire [1:0] bal_cell = (cmd_data == BAL_CELL4) ? 2'h3
                                                  : cmd_data[1:0] - 2'h1;
    wire       is_down  = (mode_reg == MODE_DOWN);

    always_comb begin
        mode_next    = mode_reg;
        level_next   = level_reg;
        mon_sel_next = mon_sel_reg;
        fet_next     = fet_reg;
        bal_next     = bal_reg;
        reg_on_next  = reg_on_reg;
        // (RL9) Charger restarts regulator
        if (is_down && charger_s) begin
            reg_on_next = 1'b1;
        end
        // (RL10) Resume and defaults
        if (cmd_strobe && cmd_addr == ADDR_RESET) begin
            mode_next    = MODE_SAVE;
            mon_sel_next = MON_SEL_RST;
            level_next   = LEVEL_3V3;
            fet_next     = FET_RST;
            bal_next     = BAL_RST;
            reg_on_next  = 1'b1;
        end else if (cmd_strobe && !is_down) begin
                case (cmd_addr)
                    ADDR_MON: begin
                        // (RL3) Select returns usual
                        mon_sel_next = cmd_data;
                        mode_next    = MODE_USUAL;
                    end
                    ADDR_FET: begin
                        fet_next = ~cmd_data;
                    end
                    ADDR_MUX: begin
                        // (RL2) Ground select saves
                        if (cmd_data == MUX_RUN) begin
                            mode_next = MODE_USUAL;
                        end else if (!cmd_data[2]) begin
                            mode_next = MODE_SAVE;
                        end
                    end
                    ADDR_REG: begin
                        // (RL14) Level select
                        if (cmd_data == REG_33A || cmd_data == REG_33B) begin
                            level_next = LEVEL_3V3;
                        end else if (cmd_data == REG_50) begin
                            level_next = LEVEL_5V0;
                        end else if (cmd_data == REG_OFF && !charger_s) begin
                            // (RL21) Off code powers down
                            // (RL6) Drives high, regulator off
                            mode_next   = MODE_DOWN;
                            fet_next    = FET_RST;
                            bal_next    = BAL_RST;
                            reg_on_next = 1'b0;
                        end
                    end
                    ADDR_BAL: begin
                        // (RL15) One cell switch
                        // (RL16) Switches accumulate
                        if (cmd_data == BAL_OFF) begin
                            bal_next = BAL_RST;
                        end else begin
                            bal_next = bal_reg | (4'h1 << bal_cell);
                        end
                    end
                    default: begin
                    end
                endcase
        end
    end

    // ------------------------------------------------------------
    // Tap switch decode; bit 2n is node n upper, 2n+1 lower
    // ------------------------------------------------------------
    // (RL22) Offset bit and cell
    wire [1:0] sel_cell   = mon_sel_reg[1:0];
    wire       sel_offset = mon_sel_reg[2];
    wire [2:0] lower_node = (sel_cell == 2'h3) ? 3'h0
                                               : {1'b0, sel_cell} + 3'h2;
    wire [2:0] upper_node = sel_offset ? lower_node
                                       : {1'b0, sel_cell} + 3'h1;
    logic [TAP_W-1:0] tap_sel;
    // (RL12) Voltage tap pair
    // (RL13) Offset tap pair
    always_comb begin
        tap_sel = '0;
        tap_sel[{upper_node, 1'b0}] = 1'b1;
        tap_sel[{lower_node, 1'b1}] = 1'b1;
    end

    // ------------------------------------------------------------
    // State and output registers
    // ------------------------------------------------------------
    logic [TAP_W-1:0] tap_reg;
    logic             det_reg;
    logic             gnd_reg;
    logic             pd_reg;
    logic             reset_n_reg;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            // (RL24) Ground select, power save
            // (RL20) Drives high at reset
            mode_reg    <= MODE_SAVE;
            level_reg   <= LEVEL_3V3;
            mon_sel_reg <= MON_SEL_RST;
            fet_reg     <= FET_RST;
            bal_reg     <= BAL_RST;
            reg_on_reg  <= 1'b1;
            tap_reg     <= '0;
            det_reg     <= 1'b0;
            gnd_reg     <= 1'b1;
            pd_reg      <= 1'b0;
            reset_n_reg <= 1'b0;
        end else begin
            // (RL1) Mode moves on commands
            mode_reg    <= mode_next;
            level_reg   <= level_next;
            mon_sel_reg <= mon_sel_next;
            // (RL7) Drives forced high
            fet_reg     <= is_down ? FET_RST : fet_next;
            bal_reg     <= bal_next;
            // (RL4) Only power-down clears
            reg_on_reg  <= reg_on_next;
            // (RL8) Taps open unless detecting
            tap_reg     <= (mode_reg == MODE_USUAL) ? tap_sel : '0;
            det_reg     <= (mode_reg == MODE_USUAL);
            gnd_reg     <= (mode_reg != MODE_USUAL);
            pd_reg      <= (mode_next == MODE_DOWN);
            // (RL11) Reset follows level
            reset_n_reg <= reg_ok_s;
        end
    end

    assign power_mode_out             = mode_reg;
    assign reg_level_out              = level_reg;
    assign regulator_enable_out       = reg_on_reg;
    assign detect_enable_out          = det_reg;
    assign monitor_ground_out         = gnd_reg;
    assign tap_switch_out             = tap_reg;
    assign balance_switch_out         = bal_reg;
    assign charge_switch_drive_out    = fet_reg[2];
    assign discharge_switch_drive_out = fet_reg[1];
    assign precharge_switch_drive_out = fet_reg[0];
    assign charger_pulldown_out       = pd_reg;
    assign link.host_reset_n          = reset_n_reg;
endmodule
`default_nettype wire

// File: rtl/afe_host.sv
// Purpose: Host end: sends 6-bit commands ordered over Avalon-MM.
// Assumes: Device reset line is asynchronous to ref_clk_in.
// Notes:   Busy covers the shift and the settle wait after it.
`default_nettype none
module afe_host
    import afe_pkg::*;
#(
    parameter int MON_SETTLE = MON_SETTLE_CYC,
    parameter int REG_SETTLE = REG_SETTLE_CYC,
    parameter int HALF_CYC   = SERIAL_HALF_CYC
) (
    input  wire logic               ref_clk_in,
    input  wire logic               reset_in,
    input  wire logic [HOST_AW-1:0] avs_address_in,
    input  wire logic               avs_read_in,
    input  wire logic               avs_write_in,
    input  wire logic [31:0]        avs_writedata_in,
    output logic      [31:0]        avs_readdata_out,
    output logic                    avs_waitrequest_out,
    afe_link_if.host                link
);

    // ------------------------------------------------------------
    // Reset line sampling
    // ------------------------------------------------------------
    logic rst_n_s;
    logic rst_n_prev_reg;

    afe_sync #(.WIDTH(1)) u_sync (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .async_in   (link.host_reset_n),
        .sync_out   (rst_n_s)
    );

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic        pend_reg;
    logic        resume_reg;
    logic [5:0]  cmd_reg;

    wire sel_cmd    = (avs_address_in == HOST_ADDR_CMD);
    wire sel_status = (avs_address_in == HOST_ADDR_STATUS);
    // Stall a command write until the previous one has settled
    wire cmd_stall  = avs_write_in & sel_cmd & (pend_reg | resume_reg);
    wire bus_take   = (avs_read_in | avs_write_in) & wait_reg & ~cmd_stall;
    wire cmd_wr     = bus_take & avs_write_in & sel_cmd;
    wire [31:0] rdata_mux =
        sel_status ? {30'h0, rst_n_s, pend_reg | resume_reg} :
        sel_cmd    ? {26'h0, cmd_reg} : 32'h0;

    // ------------------------------------------------------------
    // Serial sender
    // ------------------------------------------------------------
    host_state_t state_reg;
    logic [31:0] timer_reg;
    logic [2:0]  bits_reg;
    logic        sck_reg;
    logic        sdo_reg;
    logic        cs_n_reg;
    logic [5:0]  shift_reg;

    wire timer_done = (timer_reg == 32'h0);
    // (RL17) Monitor settle wait
    // (RL18) Regulator settle wait
    wire [31:0] settle_cyc =
        (cmd_reg[5:3] == ADDR_MON || cmd_reg[5:3] == ADDR_MUX)
            ? 32'(MON_SETTLE)
            : (cmd_reg[5:3] == ADDR_REG) ? 32'(REG_SETTLE)
                                         : 32'(HALF_CYC);

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            wait_reg       <= 1'b1;
            rdata_reg      <= 32'h0;
            pend_reg       <= 1'b0;
            resume_reg     <= 1'b0;
            cmd_reg        <= 6'h00;
            rst_n_prev_reg <= 1'b0;
            state_reg      <= H_IDLE;
            timer_reg      <= 32'h0;
            bits_reg       <= 3'h0;
            sck_reg        <= 1'b0;
            sdo_reg        <= 1'b0;
            cs_n_reg       <= 1'b1;
            shift_reg      <= 6'h00;
        end else begin
            rst_n_prev_reg <= rst_n_s;
            wait_reg       <= ~bus_take;
            if (bus_take) begin
                rdata_reg <= rdata_mux;
            end
            // (RL10) Resume after reset release
            if (rst_n_s && !rst_n_prev_reg) begin
                resume_reg <= 1'b1;
            end
            // (RL5) Sends what software orders
            if (cmd_wr) begin
                cmd_reg  <= avs_writedata_in[5:0];
                pend_reg <= 1'b1;
            end else if (resume_reg && !pend_reg && state_reg == H_IDLE) begin
                cmd_reg    <= CMD_RESUME;
                pend_reg   <= 1'b1;
                resume_reg <= 1'b0;
            end
            if (!timer_done) begin
                timer_reg <= timer_reg - 32'h1;
            end
            // (RL19) LSB first, latch on select
            case (state_reg)
                H_IDLE: begin
                    if (pend_reg) begin
                        cs_n_reg  <= 1'b0;
                        sdo_reg   <= cmd_reg[0];
                        shift_reg <= cmd_reg;
                        bits_reg  <= 3'h0;
                        timer_reg <= 32'(HALF_CYC);
                        state_reg <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    if (timer_done) begin
                        sck_reg   <= 1'b1;
                        timer_reg <= 32'(HALF_CYC);
                        state_reg <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (timer_done) begin
                        sck_reg   <= 1'b0;
                        timer_reg <= 32'(HALF_CYC);
                        if (bits_reg == CMD_BITS - 3'h1) begin
                            state_reg <= H_FINISH;
                        end else begin
                            shift_reg <= {1'b0, shift_reg[5:1]};
                            sdo_reg   <= shift_reg[1];
                            bits_reg  <= bits_reg + 3'h1;
                            state_reg <= H_SETUP;
                        end
                    end
                end
                H_FINISH: begin
                    if (timer_done) begin
                        cs_n_reg  <= 1'b1;
                        timer_reg <= settle_cyc;
                        state_reg <= H_SETTLE;
                    end
                end
                H_SETTLE: begin
                    if (timer_done) begin
                        pend_reg  <= 1'b0;
                        state_reg <= H_IDLE;
                    end
                end
                default: begin
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

    assign avs_readdata_out        = rdata_reg;
    assign avs_waitrequest_out     = wait_reg;
    assign link.serial_shift_clock = sck_reg;
    assign link.serial_data_in     = sdo_reg;
    assign link.chip_select_n      = cs_n_reg;
endmodule
`default_nettype wire

// File: tb/afe_link_sva.sv
// Purpose: Assertions on the link wires and the device mode.
// Assumes: One clock domain, synchronous reset high.
// Notes:   Inputs mirror link signal and device port names.
`default_nettype none
module afe_link_sva
    import afe_pkg::*;
(
    input wire logic             ref_clk_in,
    input wire logic             reset_in,
    input wire logic             serial_shift_clock,
    input wire logic             chip_select_n,
    input wire logic             host_reset_n,
    input wire logic             regulator_ok_in,
    input wire power_mode_t      power_mode_out,
    input wire logic             regulator_enable_out,
    input wire logic             detect_enable_out,
    input wire logic             monitor_ground_out,
    input wire logic [TAP_W-1:0] tap_switch_out
);
    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    wire logic down = power_mode_out == MODE_DOWN;

    a_sck_idle: assert property (chip_select_n |-> !serial_shift_clock)
        else $error("shift clock outside frame");
    a_gnd_inv: assert property (monitor_ground_out != detect_enable_out)
        else $error("ground and detect disagree");
    a_detect_mode: assert property (
        detect_enable_out == ($past(power_mode_out) == MODE_USUAL))
        else $error("detect out of step with mode");
    a_save_reg_on: assert property (
        power_mode_out == MODE_SAVE |-> regulator_enable_out)
        else $error("regulator off in power save");
    a_down_taps: assert property (
        $past(down) && down |-> !(|tap_switch_out))
        else $error("tap closed in power down");
    a_mode_by_cmd: assert property (
        !$stable(power_mode_out) |-> chip_select_n)
        else $error("mode changed inside a frame");
    // Five lows leave room for the synchroniser
    a_reset_low: assert property (
        !regulator_ok_in [*5] |-> !host_reset_n)
        else $error("host reset high with regulator low");
    a_pd_reg_off: assert property (
        $rose(down) |-> ##1 !regulator_enable_out)
        else $error("regulator on after power down");
endmodule
`default_nettype wire

// File: tb/battery_afe_mode_switch_control_test.sv
// Purpose: Self-checking bench joining host and device ends.
// Assumes: Short host counts keep frames brief.
// Notes:   Bench models regulator level and charger sense.
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    n_mismatch++; $display("unexpected %0t mismatch", $time); end end
module battery_afe_mode_switch_control_test import afe_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // Signals and instances
    // ------------------------------------------------
    logic ref_clk_in = 1'h0, reset_in = 1'h1, regulator_ok_in = 1'h1;
    logic charger_sense_input_in = 1'h0, avs_read_in = 1'h0;
    logic avs_write_in = 1'h0, avs_waitrequest_out, charger_pulldown_out;
    logic [3:0] avs_address_in = 4'h0, balance_switch_out;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
    logic regulator_enable_out, detect_enable_out, monitor_ground_out;
    logic charge_switch_drive_out, discharge_switch_drive_out;
    logic precharge_switch_drive_out;
    power_mode_t power_mode_out;
    reg_level_t reg_level_out;
    logic [9:0] tap_switch_out;
    int n_mismatch = 0, checks_done = 0;
    wire logic [2:0] drives = {charge_switch_drive_out,
        discharge_switch_drive_out, precharge_switch_drive_out};
    afe_link_if link ();
    afe_device afe_device_inst (.*);
    afe_host #(.MON_SETTLE(20), .REG_SETTLE(40), .HALF_CYC(4))
        afe_host_inst (.*);
    afe_link_sva afe_link_sva_inst (.*,
        .serial_shift_clock(link.serial_shift_clock),
        .chip_select_n(link.chip_select_n),
        .host_reset_n(link.host_reset_n));
    always #2 ref_clk_in = ~ref_clk_in;

    task automatic av(input logic wr, input logic [3:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= wd;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        for (int k = 0; k < 1000; k++) begin
            @(posedge ref_clk_in);
            if (avs_waitrequest_out === 1'h0) break;
        end
        `CHK(avs_waitrequest_out, 1'h0)
        rd = avs_readdata_out;
        avs_write_in <= 1'h0;
        avs_read_in <= 1'h0;
    endtask

    task automatic cmd(input logic [5:0] c);
        logic [31:0] d;
        av(1'h1, HOST_ADDR_CMD, {26'h0, c}, d);
        d = 32'h1;
        for (int k = 0; k < 300 && d[0]; k++)
            av(1'h0, HOST_ADDR_STATUS, 32'h0, d);
        `CHK(d[0], 1'h0)
        repeat (6) @(posedge ref_clk_in);
    endtask

    task automatic t_mon();
        int c, nd;
        for (int i = 0; i < 8; i++) begin
            c = i % 4;
            nd = (c == 3) ? 0 : c + 2;
            cmd({ADDR_MUX, 3'h0});
            `CHK(power_mode_out, MODE_SAVE)
            cmd({ADDR_MON, i[2:0]});
            `CHK(power_mode_out, MODE_USUAL)
            `CHK(tap_switch_out, i > 3 ? 10'h3 << 2 * nd :
                10'h1 << 2 * c + 2 | 10'h2 << 2 * nd)
        end
    endtask

    task automatic t_bal_lvl();
        cmd({ADDR_BAL, 3'h1});
        `CHK(balance_switch_out, 4'h1)
        cmd({ADDR_BAL, BAL_CELL4});
        cmd({ADDR_BAL, 3'h6});
        `CHK(balance_switch_out, 4'hb)
        cmd({ADDR_REG, REG_50});
        `CHK(reg_level_out, LEVEL_5V0)
    endtask

    task automatic t_down();
        cmd({ADDR_FET, 3'h7});
        cmd({ADDR_REG, REG_OFF});
        regulator_ok_in <= 1'h0;
        `CHK(power_mode_out, MODE_DOWN)
        `CHK({drives, regulator_enable_out}, 4'he)
        `CHK(charger_pulldown_out, 1'h1)
        cmd({ADDR_MON, 3'h1});
        `CHK(power_mode_out, MODE_DOWN)
        `CHK(link.host_reset_n, 1'h0)
        charger_sense_input_in <= 1'h1;
        repeat (6) @(posedge ref_clk_in);
        `CHK(regulator_enable_out, 1'h1)
        regulator_ok_in <= 1'h1;
        for (int k = 0; k < 900 && power_mode_out != MODE_SAVE; k++)
            @(posedge ref_clk_in);
        `CHK(power_mode_out, MODE_SAVE)
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge ref_clk_in);
        reset_in <= 1'h0;
        repeat (4) @(posedge ref_clk_in);
        `CHK({power_mode_out, tap_switch_out}, {MODE_SAVE, 10'h0})
        `CHK({drives, balance_switch_out}, 7'h70)
        `CHK(reg_level_out, LEVEL_3V3)
        t_mon();
        t_bal_lvl();
        t_down();
        print_verdict();
    end
    initial begin
        repeat (100000) @(posedge ref_clk_in);
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
